// ### hw/flash_card.sv
`include "flash_card_regs.svh"
`default_nettype none
module flash_card #(
  parameter int NUM_SECTORS = 64,
  parameter int GROUP_SECTORS = 16,
  parameter int SLEEP_CYCLES = `SLEEP_CYCLES,
  parameter logic [31:0] CARD_ID = 32'h5a3c_0f01 // Arbitrary value
) (
  input wire logic clock, // 20 MHz clock
  input wire logic arst_n, // Power-on reset
  flash_link.card link, // Command link
  input wire logic [31:0] program_fault, // Bits failing next program verify
  input wire logic [31:0] read_upset, // Bits flipped on next read
  output logic sleeping, // Low-power sleep
  output logic inactive, // Card dead until power cycle
  output logic [7:0] spare_bits, // Spare-bit replacements
  output logic [7:0] spare_sectors // Spare-sector replacements
);
  localparam int SEC_W = $clog2(NUM_SECTORS);
  localparam int EG_SHIFT = $clog2(GROUP_SECTORS);
  localparam int WPG_SHIFT = EG_SHIFT + $clog2(`WPG_GROUPS);
  localparam int NUM_GROUPS = NUM_SECTORS / GROUP_SECTORS;
  localparam int NUM_WPG = (NUM_GROUPS + `WPG_GROUPS - 1) / `WPG_GROUPS;
  localparam int SLP_W = $clog2(SLEEP_CYCLES + 1);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  initial begin
    if (GROUP_SECTORS != 16 && GROUP_SECTORS != 32) $error("group size must be 16 or 32"); // RULE14
    if (NUM_SECTORS < GROUP_SECTORS || NUM_SECTORS % GROUP_SECTORS != 0 || NUM_SECTORS > 4096)
      $error("sector count unsupported");
    if (SLEEP_CYCLES < 2) $error("sleep count too small");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  flash_card_pkg::card_state_t state;
  logic [15:0] rca;
  logic [31:0] mem [NUM_SECTORS];
  logic [NUM_SECTORS-1:0] erased;
  logic [NUM_WPG-1:0] wp;
  logic [SEC_W-1:0] op_sec;
  logic [31:0] op_data;
  logic [31:0] op_fault;
  logic [7:0] timer;
  logic [SEC_W-1:0] er_start;
  logic [SEC_W-1:0] er_end;
  logic [SEC_W-1:0] er_last;
  logic [1:0] er_tags;
  logic er_viol;
  logic mem_prog;
  logic mem_erase;
  logic bit_remap;
  logic sec_remap;
  logic [SLP_W-1:0] idle_cnt;

  // ----------------------------------------
  // Command decode helpers
  // ----------------------------------------
  logic cmd;
  logic [22:0] arg_sector;
  logic in_range;
  logic [SEC_W-1:0] sec;
  logic addressed;
  logic busy;
  logic [31:0] verify_diff;
  logic [31:0] start_wpg;
  assign cmd = link.cmd_valid && !inactive; // RULE1 RULE2
  assign arg_sector = link.cmd_arg[31:`SECTOR_SHIFT]; // RULE12 RULE13
  assign in_range = arg_sector < 23'(NUM_SECTORS);
  assign sec = arg_sector[SEC_W-1:0];
  assign addressed = link.cmd_arg[31:16] == rca;
  assign busy = state == flash_card_pkg::st_program || state == flash_card_pkg::st_erase;
  assign verify_diff = op_data ^ (op_data ^ op_fault); // RULE20
  assign start_wpg = 32'(sec) >> WPG_SHIFT; // RULE18 RULE19

  // Status word from completion codes and current state
  function automatic logic [31:0] status_word(input logic [31:0] codes,
                                              input flash_card_pkg::card_state_t s);
    logic [31:0] w;
    w = codes;
    w[`ST_STATE_LSB +: 4] = 4'(s);
    w[`ST_READY] = !(s == flash_card_pkg::st_program || s == flash_card_pkg::st_erase);
    return w;
  endfunction : status_word

  // Answer with codes and data in the given state
  task automatic answer(input logic [31:0] codes, input flash_card_pkg::card_state_t s,
                        input logic [31:0] data);
    link.resp_valid <= 1'b1;
    link.resp_status <= status_word(codes, s); // RULE9 RULE10
    link.resp_data <= data;
  endtask : answer

  // ----------------------------------------
  // Command engine
  // ----------------------------------------
  // Busy phases only answer status polls, and only while programming, so one response per cycle at most
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= flash_card_pkg::st_idle;
      inactive <= 1'b0;
      rca <= 16'h0000;
      link.resp_valid <= 1'b0;
      link.resp_status <= 32'h00000000;
      link.resp_data <= 32'h00000000;
      op_sec <= '0;
      op_data <= 32'h00000000;
      op_fault <= 32'h00000000;
      timer <= 8'h00;
      er_start <= '0;
      er_end <= '0;
      er_last <= '0;
      er_tags <= 2'h0;
      er_viol <= 1'b0;
      mem_prog <= 1'b0;
      mem_erase <= 1'b0;
      bit_remap <= 1'b0;
      sec_remap <= 1'b0;
    end else begin
      link.resp_valid <= 1'b0;
      mem_prog <= 1'b0;
      mem_erase <= 1'b0;
      bit_remap <= 1'b0;
      sec_remap <= 1'b0;
      if (busy) begin
        if (cmd && link.cmd_code == `CMD_STATUS && addressed && !mem_erase && timer > 8'h01)
          answer(32'h0, state, 32'h0); // RULE11
        if (state == flash_card_pkg::st_program) begin
          if (timer == `PROGRAM_CYCLES) mem_erase <= 1'b0;
          if (timer != 8'h00) begin
            timer <= timer - 8'h01;
          end else begin
            mem_prog <= 1'b1;
            state <= flash_card_pkg::st_transfer;
            bit_remap <= $countones(verify_diff) == 1; // RULE21
            sec_remap <= $countones(verify_diff) > 1; // RULE21
            answer(32'(verify_diff != 32'h0) << `ST_REMAPPED, flash_card_pkg::st_transfer,
                   32'h0);
          end
        end else begin
          // One sector per cycle; protected sectors are skipped and flagged
          timer <= 8'h00;
          op_sec <= op_sec + 1'b1;
          mem_erase <= !wp[32'(op_sec) >> WPG_SHIFT]; // RULE15 RULE18
          if (wp[32'(op_sec) >> WPG_SHIFT]) er_viol <= 1'b1;
          if (op_sec == er_last) begin
            state <= flash_card_pkg::st_transfer;
            answer(32'(er_viol || wp[32'(op_sec) >> WPG_SHIFT]) << `ST_WP_VIOL,
                   flash_card_pkg::st_transfer, 32'h0);
          end
        end
      end else if (cmd) begin // RULE5
        unique case (link.cmd_code)
          `CMD_OP_COND: begin
            if ((link.cmd_arg[23:0] & `CARD_VRANGE) == 24'h0) begin
              state <= flash_card_pkg::st_inactive; // RULE1
              inactive <= 1'b1;
            end else if (state == flash_card_pkg::st_idle) begin
              state <= flash_card_pkg::st_ready;
              answer(32'h0, flash_card_pkg::st_ready, 32'(`CARD_VRANGE));
            end
          end
          `CMD_ALL_SEND_ID: if (state == flash_card_pkg::st_ready) begin
            state <= flash_card_pkg::st_ident;
            answer(32'h0, flash_card_pkg::st_ident, CARD_ID); // RULE7
          end
          `CMD_SET_ADDR: if (state == flash_card_pkg::st_ident) begin
            rca <= link.cmd_arg[31:16];
            state <= flash_card_pkg::st_standby;
            answer(32'h0, flash_card_pkg::st_standby, 32'h0);
          end
          `CMD_SELECT: begin
            if (state == flash_card_pkg::st_standby && addressed) begin
              state <= flash_card_pkg::st_transfer;
              answer(32'h0, flash_card_pkg::st_transfer, 32'h0);
            end else if (state == flash_card_pkg::st_transfer && !addressed) begin
              state <= flash_card_pkg::st_standby;
            end
          end
          `CMD_ID_READ: if (state == flash_card_pkg::st_standby && addressed)
            answer(32'h0, state, CARD_ID); // RULE8
          `CMD_STATUS: if (addressed && rca != 16'h0000)
            answer(32'h0, state, 32'h0); // RULE11
          `CMD_DEACTIVATE: if (addressed && (state == flash_card_pkg::st_standby ||
                                             state == flash_card_pkg::st_transfer)) begin
            state <= flash_card_pkg::st_inactive; // RULE3
            inactive <= 1'b1;
          end
          `CMD_ID_WRITE: if (addressed && rca != 16'h0000)
            answer(32'h1 << `ST_ILLEGAL, state, 32'h0); // RULE8
          default: begin
            if (state != flash_card_pkg::st_transfer) begin
              answer(32'h1 << `ST_ILLEGAL, state, 32'h0);
            end else if (link.cmd_code == `CMD_ERASE) begin
              // Sector mode must stay inside one erase group
              if (er_tags != 2'h3 ||
                  (!link.cmd_arg[0] && (er_start >> EG_SHIFT) != (er_end >> EG_SHIFT)) ||
                  er_start > er_end) begin
                answer(32'h1 << `ST_ERASE_SEQ, state, 32'h0);
              end else begin
                op_sec <= link.cmd_arg[0] ? er_start & ~SEC_W'(GROUP_SECTORS - 1) : er_start;
                er_last <= link.cmd_arg[0] ? er_end | SEC_W'(GROUP_SECTORS - 1) : er_end; // RULE15
                er_viol <= 1'b0;
                state <= flash_card_pkg::st_erase; // RULE17
              end
              er_tags <= 2'h0;
            end else if (!in_range) begin
              answer(32'h1 << `ST_OUT_OF_RANGE, state, 32'h0);
            end else if (link.cmd_code == `CMD_READ) begin
              // Upset bits are corrected and moved onto spare bits
              bit_remap <= read_upset != 32'h0; // RULE22
              answer(32'(read_upset != 32'h0) << `ST_ECC_FIXED, state, mem[sec]);
            end else if (link.cmd_code == `CMD_WRITE) begin
              if (link.cmd_arg[`SECTOR_SHIFT-1:0] != '0) begin
                answer(32'h1 << `ST_ADDR_ERR, state, 32'h0);
              end else if (wp[start_wpg]) begin
                answer(32'h1 << `ST_WP_VIOL, state, 32'h0); // RULE18
              end else begin
                op_sec <= sec;
                op_data <= link.cmd_data;
                op_fault <= program_fault;
                mem_erase <= !erased[sec]; // RULE16
                timer <= erased[sec] ? `PROGRAM_CYCLES : `PROGRAM_CYCLES + `ERASE_CYCLES; // RULE17
                state <= flash_card_pkg::st_program;
              end
            end else if (link.cmd_code == `CMD_WP_SET || link.cmd_code == `CMD_WP_CLR) begin
              answer(32'h0, state, 32'h0);
            end else if (link.cmd_code == `CMD_ERASE_START) begin
              er_start <= sec;
              er_tags <= 2'h1;
              answer(32'h0, state, 32'h0);
            end else if (link.cmd_code == `CMD_ERASE_END && er_tags == 2'h1) begin
              er_end <= sec;
              er_tags <= 2'h3;
              answer(32'h0, state, 32'h0);
            end else begin
              er_tags <= 2'h0;
              answer(32'h1 << (link.cmd_code == `CMD_ERASE_END ? `ST_ERASE_SEQ : `ST_ILLEGAL),
                     state, 32'h0);
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Flash array, erase flags and protection
  // ----------------------------------------
  // Erased flash reads as all ones; remapped data stays correct
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_SECTORS; i++) mem[i] <= `ERASED_WORD;
      erased <= '1;
      wp <= '0;
    end else begin
      if (mem_erase) begin
        mem[state != flash_card_pkg::st_program ? op_sec - 1'b1 : op_sec] <= `ERASED_WORD;
        erased[state != flash_card_pkg::st_program ? op_sec - 1'b1 : op_sec] <= 1'b1;
      end
      if (mem_prog) begin
        mem[op_sec] <= op_data;
        erased[op_sec] <= 1'b0;
      end
      if (cmd && !busy && state == flash_card_pkg::st_transfer && in_range) begin
        if (link.cmd_code == `CMD_WP_SET) wp[start_wpg] <= 1'b1; // RULE18
        if (link.cmd_code == `CMD_WP_CLR) wp[start_wpg] <= 1'b0; // RULE18
      end
    end
  end

  // ----------------------------------------
  // Defect bookkeeping
  // ----------------------------------------
  // Counters saturate so long runs never wrap to zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      spare_bits <= 8'h00;
      spare_sectors <= 8'h00;
    end else begin
      if (bit_remap && spare_bits != 8'hff) spare_bits <= spare_bits + 8'h01; // RULE21 RULE22
      if (sec_remap && spare_sectors != 8'hff) spare_sectors <= spare_sectors + 8'h01; // RULE21
    end
  end

  // ----------------------------------------
  // Automatic sleep
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt <= '0;
      sleeping <= 1'b0;
    end else if (cmd || busy || inactive) begin
      idle_cnt <= '0;
      sleeping <= 1'b0; // RULE5
    end else if (idle_cnt == SLP_W'(SLEEP_CYCLES - 1)) begin
      sleeping <= 1'b1; // RULE4
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end
endmodule : flash_card
`default_nettype wire

// ### hw/flash_card_pkg.sv
`default_nettype none
package flash_card_pkg;
  typedef logic [5:0] cmd_t;
  typedef enum logic [3:0] {
    st_idle, st_ready, st_ident, st_standby, st_transfer, st_program, st_erase, st_inactive
  } card_state_t;
  typedef enum logic [1:0] {h_idle, h_send, h_wait} host_state_t;
endpackage : flash_card_pkg
`default_nettype wire

// ### hw/flash_card_regs.svh
// Functional notes
// RULE1: Unsupported voltage window sends card inactive, silent.
// RULE2: Only power cycling (reset) leaves inactive.
// RULE3: Deactivate command forces addressed card inactive.
// RULE4: Idle five milliseconds after operation enters sleep.
// RULE5: Any command wakes card and executes normally.
// RULE6: One host master; one outstanding command.
// RULE7: Fixed identity number used during identification.
// RULE8: Identity readable by command; writes rejected.
// RULE9: Responses carry a 32-bit status word.
// RULE10: Status holds state and last completion codes.
// RULE11: Status polling command answers current status. The card ignores polls during erase, and near the start and end of programming.
// RULE12: Addresses count bytes from zero upward.
// RULE13: 512-byte sectors, each read, written, erased.
// RULE14: Erase groups of 16 or 32 sectors.
// RULE15: Erase sectors in one group, or whole groups.
// RULE16: Write erases target before programming.
// RULE17: Pre-erased sector makes later write faster.
// RULE18: Protect groups of 32 erase groups each.
// RULE19: Highest protect group may be partial.
// RULE20: Programmed data read back and verified.
// RULE21: Defective bit to spare bit, else spare sector.
// RULE22: ECC-corrected reads also remap failing bits.
`ifndef FLASH_CARD_REGS_SVH
`define FLASH_CARD_REGS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_OP_COND 6'h01
`define CMD_ALL_SEND_ID 6'h02
`define CMD_SET_ADDR 6'h03
`define CMD_SELECT 6'h07
`define CMD_ID_READ 6'h0a
`define CMD_STATUS 6'h0d
`define CMD_DEACTIVATE 6'h0f
`define CMD_READ 6'h11
`define CMD_WRITE 6'h18
`define CMD_ID_WRITE 6'h1a
`define CMD_WP_SET 6'h1c
`define CMD_WP_CLR 6'h1d
`define CMD_ERASE_START 6'h23
`define CMD_ERASE_END 6'h24
`define CMD_ERASE 6'h26

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define ST_OUT_OF_RANGE 31
`define ST_ADDR_ERR 30
`define ST_ERASE_SEQ 28
`define ST_WP_VIOL 26
`define ST_ILLEGAL 22
`define ST_ECC_FIXED 21
`define ST_REMAPPED 20
`define ST_STATE_LSB 9
`define ST_READY 8

// ----------------------------------------
// Geometry, voltage and timing
// ----------------------------------------
`define SECTOR_SHIFT 9
`define WPG_GROUPS 32
`define CARD_VRANGE 24'hff8000
`define ERASED_WORD 32'hffffffff
`define CLOCK_MHZ 20
`define SLEEP_TIME_US 5000
`define SLEEP_CYCLES (`SLEEP_TIME_US * `CLOCK_MHZ)
`define ERASE_CYCLES 8'h08
`define PROGRAM_CYCLES 8'h04
`define HOST_TIMEOUT_CYCLES 1024

`endif

// ### hw/flash_host.sv
`include "flash_card_regs.svh"
`default_nettype none
module flash_host #(
  parameter int RESP_TIMEOUT = `HOST_TIMEOUT_CYCLES
) (
  input wire logic clock, // 20 MHz clock
  input wire logic arst_n, // Reset
  flash_link.host link, // Command link
  input wire logic req_valid, // Command request
  input wire logic [5:0] req_code, // Command code
  input wire logic [31:0] req_arg, // Command argument
  input wire logic [31:0] req_data, // Write data
  output logic req_ready, // Free to take a request
  output logic done, // Command finished pulse
  output logic done_timeout, // No card answered
  output logic [31:0] done_status, // Returned status word
  output logic [31:0] done_data // Returned data
);
  localparam int TMO_W = $clog2(RESP_TIMEOUT + 1);
  initial begin
    if (RESP_TIMEOUT < 16) $error("timeout too short for card operations");
  end

  flash_card_pkg::host_state_t state;
  logic [TMO_W-1:0] wait_cnt;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  // One command outstanding; silence ends in a timeout, which also serves enumeration
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= flash_card_pkg::h_idle;
      req_ready <= 1'b1;
      done <= 1'b0;
      done_timeout <= 1'b0;
      done_status <= 32'h00000000;
      done_data <= 32'h00000000;
      wait_cnt <= '0;
      link.cmd_valid <= 1'b0;
      link.cmd_code <= 6'h00;
      link.cmd_arg <= 32'h00000000;
      link.cmd_data <= 32'h00000000;
    end else begin
      done <= 1'b0;
      link.cmd_valid <= 1'b0;
      unique case (state)
        flash_card_pkg::h_idle: if (req_valid) begin
          link.cmd_valid <= 1'b1; // RULE6
          link.cmd_code <= req_code; // RULE3 RULE11 RULE17
          link.cmd_arg <= req_arg;
          link.cmd_data <= req_data;
          req_ready <= 1'b0;
          state <= flash_card_pkg::h_send;
        end
        flash_card_pkg::h_send: begin
          wait_cnt <= '0;
          state <= flash_card_pkg::h_wait;
        end
        flash_card_pkg::h_wait: begin
          if (link.resp_valid || wait_cnt == TMO_W'(RESP_TIMEOUT - 1)) begin
            done <= 1'b1;
            done_timeout <= !link.resp_valid;
            done_status <= link.resp_valid ? link.resp_status : 32'h00000000;
            done_data <= link.resp_valid ? link.resp_data : 32'h00000000;
            req_ready <= 1'b1;
            state <= flash_card_pkg::h_idle;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
      endcase
    end
  end
endmodule : flash_host
`default_nettype wire

// ### hw/flash_link.sv
`default_nettype none
interface flash_link;
  logic cmd_valid;
  flash_card_pkg::cmd_t cmd_code;
  logic [31:0] cmd_arg;
  logic [31:0] cmd_data;
  logic resp_valid;
  logic [31:0] resp_status;
  logic [31:0] resp_data;
  modport card (input cmd_valid, cmd_code, cmd_arg, cmd_data,
                output resp_valid, resp_status, resp_data);
  modport host (output cmd_valid, cmd_code, cmd_arg, cmd_data,
                input resp_valid, resp_status, resp_data);
endinterface : flash_link
`default_nettype wire

// ### tb/flash_card_monitor.sv
`include "flash_card_regs.svh"
`default_nettype none
module flash_card_monitor #(
  parameter int SLEEP_CYCLES = 40,
  parameter logic [31:0] CARD_ID = 32'h0000_0000
) (
  input wire logic clock, // Link clock
  input wire logic arst_n, // Power-on reset
  input wire logic cmd_valid, // Command strobe
  input wire flash_card_pkg::cmd_t cmd_code, // Command code
  input wire logic resp_valid, // Response strobe
  input wire logic [31:0] resp_status, // Status word
  input wire logic [31:0] resp_data, // Response data
  input wire logic sleeping, // Card asleep
  input wire logic inactive // Card dead
);
  timeunit 1ns;
  timeprecision 1ns;
  int quiet;

  // Quiet cycles since the link last moved; saturates so it never wraps
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      quiet <= 0;
    end else if (cmd_valid || resp_valid) begin
      quiet <= 0;
    end else if (quiet < SLEEP_CYCLES + 8) begin
      quiet <= quiet + 1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  a_resp_single_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response strobe longer than one cycle");
  a_inactive_silent: assert property (inactive |-> !resp_valid)
    else $error("inactive card answered");
  a_inactive_holds: assert property (inactive |=> inactive)
    else $error("card left inactive without reset");
  a_inactive_cause: assert property ($rose(inactive) |-> $past(cmd_valid) &&
    ($past(cmd_code) == `CMD_DEACTIVATE || $past(cmd_code) == `CMD_OP_COND))
    else $error("card went inactive without cause");
  a_status_busy_bit: assert property (resp_valid |-> resp_status[`ST_READY] ==
    !(resp_status[`ST_STATE_LSB +: 4] inside {4'h5, 4'h6}))
    else $error("ready bit disagrees with state");
  a_id_read_data: assert property (resp_valid && $past(cmd_valid) &&
    $past(cmd_code) == `CMD_ID_READ |-> resp_data == CARD_ID)
    else $error("identity read returned wrong value");
  a_id_write_refused: assert property (resp_valid && $past(cmd_valid) &&
    $past(cmd_code) == `CMD_ID_WRITE |-> resp_status[`ST_ILLEGAL])
    else $error("identity write not refused");
  a_read_answer: assert property (cmd_valid && cmd_code == `CMD_READ && !inactive
    |=> resp_valid)
    else $error("read not answered next cycle");
  a_sleep_wake: assert property (sleeping && cmd_valid && !inactive |=> !sleeping)
    else $error("command did not wake card");
  a_sleep_early: assert property ($rose(sleeping) |-> quiet >= SLEEP_CYCLES - 1)
    else $error("card slept too early");
  a_sleep_late: assert property (quiet > SLEEP_CYCLES + 2 && !inactive |-> sleeping)
    else $error("card failed to sleep");

  // Main scenarios reached
  c_id_read: cover property (resp_valid && $past(cmd_code) == `CMD_ID_READ);
  c_sleep: cover property ($rose(sleeping));
  c_inactive: cover property ($rose(inactive));
  c_protect: cover property (resp_valid && resp_status[`ST_WP_VIOL]);
endmodule : flash_card_monitor
`default_nettype wire

// ### tb/tb_flash_card_state_and_layout.sv
`include "flash_card_regs.svh"
`default_nettype none
`define CHK(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) begin \
      n_errors++; \
      $display("ERROR %0t: got %h want %h", $time, (a), (b)); \
    end \
  end
module tb_flash_card_state_and_layout;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLEEP = 40; // Short sleep span keeps the run brief
  localparam logic [31:0] ID = 32'h1234_abcd; // Arbitrary value
  localparam logic [31:0] RCA = 32'h0001_0000;
  localparam logic [31:0] GOOD = 32'h00ff_8000;
  logic clock, arst_n, req_valid, req_ready, done, done_timeout, sleeping, inactive, tmo;
  logic [5:0] req_code;
  logic [31:0] req_arg, req_data, done_status, done_data, program_fault, read_upset, st, dt;
  logic [7:0] spare_bits, spare_sectors;
  int lat, l0, n_errors, n_checks;

  // ----------------------------------------
  // Design under test
  // ----------------------------------------
  flash_link i_flash_link();
  flash_card #(.NUM_SECTORS(32), .GROUP_SECTORS(16), .SLEEP_CYCLES(SLEEP), .CARD_ID(ID))
  i_flash_card (.clock(clock), .arst_n(arst_n), .link(i_flash_link),
    .program_fault(program_fault), .read_upset(read_upset), .sleeping(sleeping),
    .inactive(inactive), .spare_bits(spare_bits), .spare_sectors(spare_sectors));
  flash_host #(.RESP_TIMEOUT(60)) i_flash_host (.clock(clock), .arst_n(arst_n),
    .link(i_flash_link), .req_valid(req_valid), .req_code(req_code), .req_arg(req_arg),
    .req_data(req_data), .req_ready(req_ready), .done(done), .done_timeout(done_timeout),
    .done_status(done_status), .done_data(done_data));
  flash_card_monitor #(.SLEEP_CYCLES(SLEEP), .CARD_ID(ID)) i_flash_card_monitor (
    .clock(clock), .arst_n(arst_n), .cmd_valid(i_flash_link.cmd_valid),
    .cmd_code(i_flash_link.cmd_code), .resp_valid(i_flash_link.resp_valid),
    .resp_status(i_flash_link.resp_status), .resp_data(i_flash_link.resp_data),
    .sleeping(sleeping), .inactive(inactive));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic do_reset;
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
  endtask : do_reset

  // One command through the host; sampled at negedge so flops have settled
  task automatic xfer(input logic [5:0] code, input logic [31:0] arg, input logic [31:0] data);
    @(posedge clock);
    req_valid <= 1'b1;
    req_code <= code;
    req_arg <= arg;
    req_data <= data;
    @(posedge clock);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clock);
      lat++;
    end while (done !== 1'b1 && lat < 100);
    `CHK({done, req_ready}, 2'b11)
    st = done_status;
    dt = done_data;
    tmo = done_timeout;
  endtask : xfer

  task automatic give_verdict;
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ident;
    xfer(`CMD_OP_COND, GOOD, 32'h0);
    `CHK(tmo, 1'b0)
    xfer(`CMD_ALL_SEND_ID, 32'h0, 32'h0);
    `CHK(dt, ID)
    xfer(`CMD_SET_ADDR, RCA, 32'h0);
    xfer(`CMD_ID_WRITE, RCA, ~ID);
    `CHK(st[`ST_ILLEGAL], 1'b1)
    xfer(`CMD_ID_READ, RCA, 32'h0);
    `CHK(dt, ID)
    xfer(`CMD_SELECT, RCA, 32'h0);
    xfer(`CMD_STATUS, RCA, 32'h0);
    `CHK(st[12:8], 5'h09)
  endtask : t_ident

  task automatic t_memory;
    xfer(`CMD_WRITE, 32'h200, 32'hc3a5_0f96);
    l0 = lat;
    xfer(`CMD_READ, 32'h3f5, 32'h0);
    `CHK(dt, 32'hc3a5_0f96)
    xfer(`CMD_WRITE, 32'h201, 32'h0);
    `CHK(st[`ST_ADDR_ERR], 1'b1)
    xfer(`CMD_READ, 32'h4000, 32'h0);
    `CHK(st[`ST_OUT_OF_RANGE], 1'b1)
    xfer(`CMD_READ, 32'h3fff, 32'h0);
    `CHK(st[`ST_OUT_OF_RANGE], 1'b0)
    // Overwrite pays the erase time; a pre-erased sector does not
    xfer(`CMD_WRITE, 32'h200, 32'h5a5a_1234);
    `CHK(lat - l0, int'(`ERASE_CYCLES))
    xfer(`CMD_ERASE_START, 32'h200, 32'h0);
    xfer(`CMD_ERASE_END, 32'h200, 32'h0);
    xfer(`CMD_ERASE, 32'h0, 32'h0);
    `CHK(st[`ST_ERASE_SEQ], 1'b0)
    xfer(`CMD_READ, 32'h200, 32'h0);
    `CHK(dt, `ERASED_WORD)
    xfer(`CMD_WRITE, 32'h200, 32'h1);
    `CHK(lat, l0)
    xfer(`CMD_ERASE, 32'h1, 32'h0);
    `CHK(st[`ST_ERASE_SEQ], 1'b1)
    xfer(`CMD_WRITE, 32'h2200, 32'h7);
    xfer(`CMD_ERASE_START, 32'h0, 32'h0);
    xfer(`CMD_ERASE_END, 32'h2000, 32'h0);
    xfer(`CMD_ERASE, 32'h1, 32'h0);
    xfer(`CMD_READ, 32'h2200, 32'h0);
    `CHK(dt, `ERASED_WORD)
    xfer(`CMD_WP_SET, 32'h0, 32'h0);
    xfer(`CMD_WRITE, 32'h400, 32'h9);
    `CHK(st[`ST_WP_VIOL], 1'b1)
    xfer(`CMD_WP_CLR, 32'h0, 32'h0);
    xfer(`CMD_WRITE, 32'h400, 32'h9);
    `CHK(st[`ST_WP_VIOL], 1'b0)
  endtask : t_memory

  task automatic t_faults;
    @(posedge clock);
    program_fault <= 32'h0000_0010;
    xfer(`CMD_WRITE, 32'h600, 32'h0f0f_0f0f);
    `CHK(spare_bits, 8'h01)
    @(posedge clock) program_fault <= 32'h0000_0300;
    xfer(`CMD_WRITE, 32'h800, 32'h3c3c_a5a5);
    `CHK(spare_sectors, 8'h01)
    @(posedge clock) program_fault <= 32'h0;
    xfer(`CMD_READ, 32'h600, 32'h0);
    `CHK(dt, 32'h0f0f_0f0f)
    @(posedge clock) read_upset <= 32'h0000_0004;
    xfer(`CMD_READ, 32'h800, 32'h0);
    @(posedge clock) read_upset <= 32'h0;
    `CHK(dt, 32'h3c3c_a5a5)
    `CHK({st[21:20], spare_bits}, 10'h202)
  endtask : t_faults

  task automatic t_sleep;
    repeat (SLEEP + 5) @(negedge clock);
    `CHK(sleeping, 1'b1)
    xfer(`CMD_STATUS, RCA, 32'h0);
    `CHK({tmo, sleeping, st[12:9]}, 6'h04)
  endtask : t_sleep

  task automatic t_inactive;
    xfer(`CMD_DEACTIVATE, RCA, 32'h0);
    `CHK({tmo, inactive}, 2'b11)
    xfer(`CMD_STATUS, RCA, 32'h0);
    `CHK(tmo, 1'b1)
    do_reset;
    xfer(`CMD_OP_COND, 32'h0000_0100, 32'h0);
    `CHK({tmo, inactive}, 2'b11)
    xfer(`CMD_OP_COND, GOOD, 32'h0);
    `CHK(tmo, 1'b1)
    do_reset;
    xfer(`CMD_OP_COND, GOOD, 32'h0);
    `CHK({tmo, inactive}, 2'b00)
  endtask : t_inactive

  // Main sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_code = 6'h00;
    req_arg = 32'h0;
    req_data = 32'h0;
    program_fault = 32'h0;
    read_upset = 32'h0;
    do_reset;
    t_ident;
    t_memory;
    t_faults;
    t_sleep;
    t_inactive;
    give_verdict;
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    give_verdict;
  end
endmodule : tb_flash_card_state_and_layout
`default_nettype wire
